//--- color_stn_panel_timing.sv
/*
 * timing generator for passive colour panels: 4-bit colour and 8-bit
 * colour format 1. makes frame, line, shift clocks, pixel data, ac drive.
 * assumes: pixel source on sys_clk answers pixelTake within one Ts;
 * register file reached over the plain strobe port.
 */
//
// Functional notes
// R01: vertical display lines are field plus one
// R02: vertical blank lines are field plus one
// R03: horizontal display is (field plus one) times 8
// R04: horizontal blank is (field plus one) times 8
// R05: line period is display plus blank
// R06: frame rises line period minus 12 early
// R07: frame holds 12; line pulse 11 wide
// R08: ac drive toggles 3 or programmed delay
// R09: 4-bit shift clock period one Ts
// R10: 4-bit data on upper lines, centred
// R11: 4-bit first fall 19.5 or 17.5
// R12: 4-bit last fall before line rise
// R13: 4-bit last fall before line fall
// R14: first shift rise 19/17 or 18/16
// R15: 8-bit two shift clocks, period four
// R16: 8-bit data on eight lines, centred
// R17: 8-bit first events at 20 or 18
// R18: 8-bit secondary last fall before line
// R19: 8-bit primary last edges counted back
// R20: count in Ts using half-period steps
// R21: frame marks first vertical display line
`timescale 1ns/100ps
`include "color_stn_map.svh"

module color_stn_panel_timing #(
	parameter int HALF_DIV = `CSTN_HALF_DIV_DEFAULT // sys_clk per half Ts
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic [7:0] pixelIn,
	output logic pixelTake,
	output logic framePulse,
	output logic linePulse,
	output logic primaryShiftClock,
	output logic secondaryShiftClock,
	output logic [7:0] panelPixelData,
	output logic acDriveOutput
);

	// ==========================================================
	// constants in half-Ts steps; DIV_LAST in sys_clk cycles
	localparam logic [11:0] HALVES = 12'(`CSTN_HALVES_PER_TS);
	localparam logic [11:0] LINE_W_H = 12'(`CSTN_LINE_WIDTH_TS * HALVES);
	localparam logic [11:0] FRAME_H = 12'(`CSTN_FRAME_HOLD_TS * HALVES);
	localparam logic [11:0] AC_BASE_H = 12'(`CSTN_AC_BASE_TS * HALVES);
	localparam logic [11:0] S4_H = 12'(`CSTN_SHIFT4_RISE_TS * HALVES);
	localparam logic [11:0] S4D_H = 12'(`CSTN_SHIFT4_RISE16_TS * HALVES);
	localparam logic [11:0] S8_H = 12'(`CSTN_SHIFT8_RISE_TS * HALVES);
	localparam logic [11:0] S8D_H = 12'(`CSTN_SHIFT8_RISE16_TS * HALVES);
	localparam logic [11:0] TAIL4_H = 12'(`CSTN_SHIFT4_TAIL_TS * HALVES);
	localparam logic [2:0] LOAD8_H = 3'(`CSTN_SHIFT8_LOAD_H);
	localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

	// ==========================================================
	// register file and shared configuration
	panel_cfg_if cfg (); // configuration and status carrier

	panel_regs regs (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrite(regWrite),
		.regRead(regRead),
		.regRdData(regRdData),
		.cfg(cfg.regs)
	);

	color_stn_pkg::timing_state_type st_r; // registered state
	color_stn_pkg::timing_state_type st_nxt; // next state

	// ==========================================================
	// derived periods; hdpH, hndpH, lineH, acDelayH and startH in half-Ts steps
	logic [7:0] hDispP1; // display width in units of 8 Ts
	logic [5:0] hBlankP1; // blank width in units of 8 Ts
	logic [11:0] hdpH; // horizontal display period
	logic [11:0] hndpH; // horizontal blank period
	logic [11:0] lineH; // whole line period
	logic [10:0] vDispP1; // display lines
	logic [6:0] vBlankP1; // blank lines
	logic [10:0] vTotal; // lines per frame
	logic [7:0] acP1; // ac delay in units of 8 Ts
	logic [11:0] acDelayH; // ac-drive delay after line fall
	logic [11:0] startH; // first primary shift rise
	logic [11:0] shiftPos; // position inside the shift window
	logic halfEn; // one-cycle enable per half Ts
	logic lineEnd; // last half step of the line
	logic vDisplay; // current line is a display line
	logic afterStart; // past the first shift rise
	logic win4; // 4-bit shift window
	logic win8; // 8-bit shift window
	logic load4; // 4-bit pixel load point
	logic load8; // 8-bit pixel load point

	// R03: display period times 8
	assign hDispP1 = {1'b0, cfg.hDispField} + 8'h01;
	assign hdpH = {hDispP1, 4'h0};
	// R04: blank period times 8
	assign hBlankP1 = {1'b0, cfg.hBlankField} + 6'h01;
	assign hndpH = {2'h0, hBlankP1, 4'h0};
	// R05: line period sum
	assign lineH = hdpH + hndpH;
	// R01: display lines plus one
	assign vDispP1 = {1'b0, cfg.vDispField} + 11'h001;
	// R02: blank lines plus one
	assign vBlankP1 = {1'b0, cfg.vBlankField} + 7'h01;
	assign vTotal = vDispP1 + {4'h0, vBlankP1};

	// R08: short or programmed delay
	assign acP1 = {1'b0, cfg.acDelayField} + 8'h01;
	assign acDelayH = (cfg.acRateField == 6'h00) ? AC_BASE_H :
		({acP1, 4'h0} + AC_BASE_H);

	// R20: half-Ts enable divider
	assign halfEn = (st_r.divCnt == DIV_LAST);
	assign lineEnd = (st_r.hCnt >= (lineH - 12'h001));
	assign vDisplay = (st_r.vCnt < vDispP1);

	// R14: first shift rise per mode and depth
	always_comb begin
		startH = S4_H;
		case (cfg.mode)
			color_stn_pkg::MODE_COLOR4: startH = cfg.deepColor ? S4D_H : S4_H;
			color_stn_pkg::MODE_COLOR8F1: begin
				startH = cfg.deepColor ? S8D_H : S8_H;
			end
			default: startH = S4_H;
		endcase
	end

	assign afterStart = (st_r.hCnt >= startH);
	assign shiftPos = st_r.hCnt - startH;

	// R12: 4-bit window ends hdpH minus TAIL4_H past the first rise
	// R13: last rise sits three Ts short of display, last fall half a Ts later
	assign win4 = vDisplay && afterStart &&
		(shiftPos <= (hdpH - TAIL4_H));
	// R18: secondary window closes at display end
	// R19: primary last fall one event earlier
	assign win8 = vDisplay && afterStart && (shiftPos < hdpH);
	// R10: load on each rising half
	assign load4 = win4 && !shiftPos[0];
	// R16: load one Ts before each primary fall
	assign load8 = win8 && (shiftPos[2:0] == LOAD8_H);

	// ==========================================================
	// next-state logic: divider, counters and registered panel pins
	always_comb begin
		st_nxt = st_r;
		st_nxt.take = 1'b0;
		// divider free runs; wraps on its last count
		st_nxt.divCnt = halfEn ? 8'h00 : (st_r.divCnt + 8'h01);
		// marks the first sys_clk after the counters moved
		st_nxt.fresh = halfEn;
		if (!cfg.enable) begin
			// idle panel: everything parked low
			st_nxt.hCnt = 12'h000;
			st_nxt.vCnt = 11'h000;
			st_nxt.frame = 1'b0;
			st_nxt.line = 1'b0;
			st_nxt.pShift = 1'b0;
			st_nxt.sShift = 1'b0;
			st_nxt.data = 8'h00;
			st_nxt.ac = 1'b0;
		end else begin
			if (halfEn) begin
				// R05: line counter wrap
				if (lineEnd) begin
					st_nxt.hCnt = 12'h000;
					// counts past the frame end restart at line zero
					if (st_r.vCnt >= (vTotal - 11'h001)) begin
						st_nxt.vCnt = 11'h000;
					end else begin
						st_nxt.vCnt = st_r.vCnt + 11'h001;
					end
				end else begin
					st_nxt.hCnt = st_r.hCnt + 12'h001;
				end
			end
			// R07: line pulse eleven Ts wide
			st_nxt.line = (st_r.hCnt >= (lineH - LINE_W_H));
			// R06: frame rises on the last blank line
			// R21: frame ends inside display line zero
			st_nxt.frame =
				((st_r.vCnt == (vTotal - 11'h001)) &&
				(st_r.hCnt >= FRAME_H)) ||
				((st_r.vCnt == 11'h000) && (st_r.hCnt < FRAME_H));
			// R08: ac drive toggles once per line when acDelayH lies below lineH
			if (st_r.fresh && (st_r.hCnt == acDelayH)) begin
				st_nxt.ac = !st_r.ac;
			end
			case (cfg.mode)
				color_stn_pkg::MODE_COLOR4: begin
					// R09: high on even half, low on odd half
					// R11: first fall half a Ts after the rise
					st_nxt.pShift = win4 && !shiftPos[0];
					st_nxt.sShift = 1'b0;
					if (st_r.fresh && load4) begin
						// R10: nibble on the upper four lines
						st_nxt.data = {pixelIn[3:0], 4'h0};
						st_nxt.take = 1'b1;
					end
				end
				color_stn_pkg::MODE_COLOR8F1: begin
					// R15: primary high two Ts, secondary opposite
					// R17: first event four halves after start
					st_nxt.pShift = win8 && !shiftPos[2];
					st_nxt.sShift = win8 && shiftPos[2];
					if (st_r.fresh && load8) begin
						// R16: full byte on all eight lines
						st_nxt.data = pixelIn;
						st_nxt.take = 1'b1;
					end
				end
				default: begin
					st_nxt.pShift = 1'b0;
					st_nxt.sShift = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// state register; every panel pin leaves straight from here
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// pins and status
	assign framePulse = st_r.frame;
	assign linePulse = st_r.line;
	assign primaryShiftClock = st_r.pShift;
	assign secondaryShiftClock = st_r.sShift;
	assign panelPixelData = st_r.data;
	assign acDriveOutput = st_r.ac;
	assign pixelTake = st_r.take;
	// status read back through the register file
	assign cfg.displayActive = vDisplay && cfg.enable;
	assign cfg.lineBusy = st_r.line;
	assign cfg.frameBusy = st_r.frame;

endmodule // color_stn_panel_timing

//--- color_stn_map.svh
/*
 * register offsets, field positions, reset values and panel timing counts
 * for the passive colour panel timing block.
 * assumes: included by bare name; pixel-clock figures in whole Ts units.
 */
`ifndef COLOR_STN_MAP_SVH
`define COLOR_STN_MAP_SVH

// ==========================================================
// register offsets (byte addresses on the plain port)
`define CSTN_ADDR_AC_RATE 8'h31
`define CSTN_ADDR_HDISP 8'h32
`define CSTN_ADDR_BLANK 8'h34
`define CSTN_ADDR_VDISP_LO 8'h38
`define CSTN_ADDR_VDISP_HI 8'h39
`define CSTN_ADDR_MODE 8'h40
`define CSTN_ADDR_STATUS 8'h41

// ==========================================================
// reset values
`define CSTN_RST_AC_RATE 8'h00
`define CSTN_RST_HDISP 8'h00
`define CSTN_RST_BLANK 8'h00
`define CSTN_RST_VDISP_LO 8'h00
`define CSTN_RST_VDISP_HI 8'h00
`define CSTN_RST_MODE 8'h00

// ==========================================================
// field positions
`define CSTN_MODE_ENABLE_BIT 0
`define CSTN_MODE_EIGHT_BIT 1
`define CSTN_MODE_DEEP_BIT 2
`define CSTN_STAT_DISP_BIT 0
`define CSTN_STAT_LINE_BIT 1
`define CSTN_STAT_FRAME_BIT 2

// ==========================================================
// timing, in pixel-clock periods (Ts); CSTN_SHIFT8_LOAD_H in half Ts, CSTN_HALF_DIV_DEFAULT in sys_clk
`define CSTN_HALVES_PER_TS 2
`define CSTN_HALF_DIV_DEFAULT 1
`define CSTN_LINE_WIDTH_TS 11
`define CSTN_FRAME_HOLD_TS 12
`define CSTN_AC_BASE_TS 3
`define CSTN_SHIFT4_RISE_TS 19
`define CSTN_SHIFT4_RISE16_TS 17
`define CSTN_SHIFT8_RISE_TS 18
`define CSTN_SHIFT8_RISE16_TS 16
`define CSTN_SHIFT4_TAIL_TS 3
`define CSTN_SHIFT8_LOAD_H 2

`endif

//--- color_stn_pkg.sv
/*
 * types shared by the colour panel timing block and its register file.
 * assumes: color_stn_map.svh sits in the same folder.
 */
`include "color_stn_map.svh"

package color_stn_pkg;

	// ==========================================================
	// panel modes
	typedef enum logic [0:0] {
		MODE_COLOR4 = 1'b0,
		MODE_COLOR8F1 = 1'b1
	} panel_mode_type;

	// ==========================================================
	// register file state
	typedef struct packed {
		logic [7:0] acRate;
		logic [7:0] hDisp;
		logic [7:0] blank;
		logic [7:0] vDispLo;
		logic [7:0] vDispHi;
		logic [7:0] modeCtrl;
		logic [7:0] rdData;
	} regs_state_type;

	// ==========================================================
	// timing generator state
	typedef struct packed {
		logic [7:0] divCnt;
		logic fresh;
		logic [11:0] hCnt;
		logic [10:0] vCnt;
		logic frame;
		logic line;
		logic pShift;
		logic sShift;
		logic [7:0] data;
		logic ac;
		logic take;
	} timing_state_type;

endpackage

//--- panel_cfg_if.sv
/*
 * configuration and status carried between register file and timing core.
 * assumes: both ends run on sys_clk.
 */
`timescale 1ns/100ps

interface panel_cfg_if;
	logic [6:0] hDispField; // horizontal display, units of 8 Ts, minus one
	logic [4:0] hBlankField; // horizontal blank, units of 8 Ts, minus one
	logic [5:0] vBlankField; // vertical blank lines minus one
	logic [9:0] vDispField; // vertical display lines minus one
	logic [6:0] acDelayField; // ac-drive delay field
	logic [5:0] acRateField; // zero selects the short ac-drive delay
	logic enable; // timing runs
	color_stn_pkg::panel_mode_type mode; // 4-bit or 8-bit format 1
	logic deepColor; // 15/16 bpp offsets
	logic displayActive; // current line lies in vertical display
	logic lineBusy; // line pulse high
	logic frameBusy; // frame pulse high

	modport regs (
		output hDispField, hBlankField, vBlankField, vDispField,
		output acDelayField, acRateField, enable, mode, deepColor,
		input displayActive, lineBusy, frameBusy
	);

	modport timing (
		input hDispField, hBlankField, vBlankField, vDispField,
		input acDelayField, acRateField, enable, mode, deepColor,
		output displayActive, lineBusy, frameBusy
	);
endinterface // panel_cfg_if

//--- panel_regs.sv
/*
 * register file for the colour panel timing block on a plain strobe port.
 * assumes: one-cycle strobes, never both at once; read data the next cycle.
 */
`timescale 1ns/100ps
`include "color_stn_map.svh"

module panel_regs (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	panel_cfg_if.regs cfg
);

	color_stn_pkg::regs_state_type st_r; // registered state
	color_stn_pkg::regs_state_type st_nxt; // next state

	// ==========================================================
	// write decode and read mux; unmapped reads give zero
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdData = 8'h00;
		if (regWrite) begin
			case (regAddr)
				`CSTN_ADDR_AC_RATE: st_nxt.acRate = regWrData;
				`CSTN_ADDR_HDISP: st_nxt.hDisp = regWrData;
				`CSTN_ADDR_BLANK: st_nxt.blank = regWrData;
				`CSTN_ADDR_VDISP_LO: st_nxt.vDispLo = regWrData;
				`CSTN_ADDR_VDISP_HI: st_nxt.vDispHi = regWrData;
				`CSTN_ADDR_MODE: st_nxt.modeCtrl = regWrData;
				default: st_nxt.acRate = st_r.acRate;
			endcase
		end
		if (regRead) begin
			case (regAddr)
				`CSTN_ADDR_AC_RATE: st_nxt.rdData = {2'h0, st_r.acRate[5:0]};
				`CSTN_ADDR_HDISP: st_nxt.rdData = {1'h0, st_r.hDisp[6:0]};
				`CSTN_ADDR_BLANK: st_nxt.rdData = st_r.blank;
				`CSTN_ADDR_VDISP_LO: st_nxt.rdData = st_r.vDispLo;
				`CSTN_ADDR_VDISP_HI: st_nxt.rdData = {6'h00, st_r.vDispHi[1:0]};
				`CSTN_ADDR_MODE: st_nxt.rdData = {5'h00, st_r.modeCtrl[2:0]};
				`CSTN_ADDR_STATUS: begin
					st_nxt.rdData[`CSTN_STAT_DISP_BIT] = cfg.displayActive;
					st_nxt.rdData[`CSTN_STAT_LINE_BIT] = cfg.lineBusy;
					st_nxt.rdData[`CSTN_STAT_FRAME_BIT] = cfg.frameBusy;
				end
				default: st_nxt.rdData = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r.acRate <= `CSTN_RST_AC_RATE;
			st_r.hDisp <= `CSTN_RST_HDISP;
			st_r.blank <= `CSTN_RST_BLANK;
			st_r.vDispLo <= `CSTN_RST_VDISP_LO;
			st_r.vDispHi <= `CSTN_RST_VDISP_HI;
			st_r.modeCtrl <= `CSTN_RST_MODE;
			st_r.rdData <= 8'h00;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// fields toward the timing core
	// R01: vertical display field join
	assign cfg.vDispField = {st_r.vDispHi[1:0], st_r.vDispLo};
	// R02: vertical blank field
	assign cfg.vBlankField = st_r.blank[5:0];
	// R03: horizontal display field
	assign cfg.hDispField = st_r.hDisp[6:0];
	// R04: horizontal blank field
	assign cfg.hBlankField = st_r.blank[4:0];
	assign cfg.acDelayField = st_r.blank[6:0];
	assign cfg.acRateField = st_r.acRate[5:0];
	assign cfg.enable = st_r.modeCtrl[`CSTN_MODE_ENABLE_BIT];
	assign cfg.mode = color_stn_pkg::panel_mode_type'(
		st_r.modeCtrl[`CSTN_MODE_EIGHT_BIT]);
	assign cfg.deepColor = st_r.modeCtrl[`CSTN_MODE_DEEP_BIT];
	assign regRdData = st_r.rdData;

endmodule // panel_regs

//--- color_stn_panel_timing_assertions.sv
/*
 * checker for the colour panel timing block, bound to its top ports.
 * assumes: config is shadowed from port writes; a line is judged only
 * once a line fall has passed since the last write.
 */
`timescale 1ns/100ps

module color_stn_panel_timing_assertions #(
	parameter int HALF_DIV = 1 // sys_clk per half Ts
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	input wire logic [7:0] pixelIn,
	input wire logic pixelTake,
	input wire logic framePulse,
	input wire logic linePulse,
	input wire logic primaryShiftClock,
	input wire logic secondaryShiftClock,
	input wire logic [7:0] panelPixelData,
	input wire logic acDriveOutput
);
	// ==========================================================
	// shadow config and a counter from the line pulse fall
	logic [7:0] hdCfg_r, blCfg_r, acCfg_r, modeCfg_r; // shadowed registers
	logic [15:0] since_r; // cycles since line fall, 1 on the next edge
	logic lineDly_r; // line pulse one edge back
	logic steady_r; // a line fall has passed since the last write
	logic m8; // 8-bit format 1
	int lineH, hdpH, q, acH; // figures in half Ts; q in sys_clk cycles

	// shadow writes to 0x31, 0x32, 0x34 and 0x40; any write voids the current measurement
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{hdCfg_r, blCfg_r, acCfg_r, modeCfg_r} <= '0;
			{since_r, lineDly_r, steady_r} <= '0;
		end else begin
			lineDly_r <= linePulse;
			since_r <= (lineDly_r && !linePulse) ? 16'h0001 : since_r + 16'h0001;
			steady_r <= !regWrite && (steady_r || (lineDly_r && !linePulse));
			if (regWrite && regAddr == 8'h31) acCfg_r <= regWrData;
			if (regWrite && regAddr == 8'h32) hdCfg_r <= regWrData;
			if (regWrite && regAddr == 8'h34) blCfg_r <= regWrData;
			if (regWrite && regAddr == 8'h40) modeCfg_r <= regWrData;
		end
	end

	// expected figures worked out from the shadowed fields
	always_comb begin
		m8 = modeCfg_r[1];
		lineH = 16 * (int'(hdCfg_r[6:0]) + int'(blCfg_r[4:0]) + 2);
		hdpH = 16 * (int'(hdCfg_r[6:0]) + 1);
		q = int'(since_r) - HALF_DIV * (m8 ? (modeCfg_r[2] ? 32 : 36) :
			(modeCfg_r[2] ? 34 : 38));
		acH = (acCfg_r[5:0] == 6'h00) ? 6 :
			2 * (8 * (int'(blCfg_r[6:0]) + 1) + 3);
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_line_period: assert property (
		$fell(linePulse) && steady_r |-> int'(since_r) == lineH * HALF_DIV)
		else $error("line period wrong");
	a_line_width: assert property (
		$rose(linePulse) && steady_r |-> int'(since_r) == (lineH - 22) * HALF_DIV)
		else $error("line pulse width wrong");
	a_frame_edges: assert property (
		($rose(framePulse) || $fell(framePulse)) && steady_r
		|-> int'(since_r) == 24 * HALF_DIV)
		else $error("frame pulse edge misplaced");
	a_shift_phase: assert property (
		$rose(primaryShiftClock) && steady_r |-> q >= 0 &&
		q % ((m8 ? 8 : 2) * HALF_DIV) == 0 &&
		q <= (m8 ? hdpH - 8 : hdpH - 6) * HALF_DIV)
		else $error("primary shift edge misplaced");
	a_second_phase: assert property (
		$rose(secondaryShiftClock) && steady_r |-> m8 && q >= 4 * HALF_DIV &&
		(q - 4 * HALF_DIV) % (8 * HALF_DIV) == 0)
		else $error("secondary shift edge misplaced");
	a_clocks_apart: assert property (
		steady_r && m8 |-> !(primaryShiftClock && secondaryShiftClock))
		else $error("shift clocks overlap");
	a_second_idle: assert property (
		steady_r && !m8 |-> !secondaryShiftClock)
		else $error("secondary shift active in 4-bit mode");
	a_take_shift: assert property (
		pixelTake && steady_r && !m8 |-> $rose(primaryShiftClock))
		else $error("pixel load off the shift rise");
	a_nibble_low: assert property (
		steady_r && !m8 |-> panelPixelData[3:0] == 4'h0)
		else $error("lower data lines driven in 4-bit mode");
	a_ac_delay: assert property (
		$changed(acDriveOutput) && steady_r |-> int'(since_r) == acH * HALF_DIV)
		else $error("ac drive toggle misplaced");
	a_read_idle: assert property (
		!$past(regRead) |-> regRdData == 8'h00)
		else $error("read data outside its cycle");
endmodule // color_stn_panel_timing_assertions

//--- panel_model.sv
/*
 * panel side model: counts primary shift falls per line and latches the
 * data there, reporting both as the next line pulse rises.
 * assumes: sampled on sys_clk, which is faster than any shift edge.
 */
`timescale 1ns/100ps

module panel_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic linePulse,
	input wire logic primaryShiftClock,
	input wire logic [7:0] panelPixelData,
	output logic lineDone,
	output logic [7:0] shiftCount,
	output logic [7:0] lastData
);
	// ==========================================================
	// edge finding and per-line counting
	logic shiftDly_r, lineDly_r; // inputs one edge back
	logic [7:0] cnt_r; // shift falls seen in this line

	// report on line rise; the count restarts there
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{shiftDly_r, lineDly_r, lineDone, shiftCount, lastData, cnt_r} <= '0;
		end else begin
			shiftDly_r <= primaryShiftClock;
			lineDly_r <= linePulse;
			lineDone <= linePulse && !lineDly_r;
			if (linePulse && !lineDly_r) begin
				shiftCount <= cnt_r;
				cnt_r <= 8'h00;
			end else if (shiftDly_r && !primaryShiftClock) begin
				cnt_r <= cnt_r + 8'h01;
				lastData <= panelPixelData;
			end
		end
	end
endmodule // panel_model

//--- tb_top.sv
/*
 * self-checking bench for the colour panel timing block.
 * assumes: HALF_DIV 1, so one half Ts is one sys_clk; panel model beside.
 */
`timescale 1ns/100ps

module tb_top;
	// ==========================================================
	// clock, reset, stimulus and bookkeeping
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1; // held for 8 cycles
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, pixelIn = 8'h00;
	logic regWrite = 1'b0, regRead = 1'b0;
	logic [7:0] regRdData, panelPixelData, shiftCount, lastData;
	logic pixelTake, framePulse, linePulse, primaryShiftClock;
	logic secondaryShiftClock, acDriveOutput, lineDone;
	logic [7:0] rnd = 8'h04; // random source state
	logic [7:0] expCnt = 8'h00; // shifts per display line
	logic rdDly = 1'b0, lineWas = 1'b0, armed = 1'b0, go = 1'b0, m8 = 1'b0;
	logic [15:0] ent; // popped note
	logic [15:0] rdQ[$]; // read notes: mask, value
	logic [15:0] lnQ[$]; // line notes: count, data
	int errors = 0, checks_done = 0, vLine = 0, lines = 0, base = 0;
	logic [7:0] rstAddr[8] = '{8'h31, 8'h32, 8'h34, 8'h38, 8'h39, 8'h40, 8'h41,
		8'h7F};
	logic [7:0] wbAddr[4] = '{8'h31, 8'h32, 8'h39, 8'h7F};
	logic [7:0] wbExp[4] = '{8'h3F, 8'h7F, 8'h03, 8'h00}; // reserved read 0

	always #2 sys_clk = ~sys_clk;

	color_stn_panel_timing #(.HALF_DIV(1)) u_color_stn_panel_timing (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .pixelIn(pixelIn), .pixelTake(pixelTake),
		.framePulse(framePulse), .linePulse(linePulse),
		.primaryShiftClock(primaryShiftClock),
		.secondaryShiftClock(secondaryShiftClock),
		.panelPixelData(panelPixelData), .acDriveOutput(acDriveOutput));

	panel_model u_panel_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.linePulse(linePulse), .primaryShiftClock(primaryShiftClock),
		.panelPixelData(panelPixelData), .lineDone(lineDone),
		.shiftCount(shiftCount), .lastData(lastData));

	// ==========================================================
	// helpers
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic check(input logic [7:0] seen, exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test;
		if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// one-cycle strobes; a spare edge keeps strobe changes apart
	task automatic wr(input logic [7:0] a, d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, e, m);
		rdQ.push_back({m, e});
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		@(posedge sys_clk);
	endtask

	// ==========================================================
	// line driver: new random pixel per line, note what the panel sees
	always @(posedge sys_clk) begin
		lineWas <= linePulse;
		if (!go) begin
			armed = 1'b0;
			lnQ.delete();
		end else if (lineWas && !linePulse) begin
			// two display and four blank lines per frame
			if (armed && framePulse)
				check(8'(vLine), 8'h05, "lines per frame");
			vLine = framePulse ? 0 : vLine + 1;
			armed = armed | framePulse;
			rnd = lfsr(rnd);
			pixelIn <= rnd;
			if (armed && vLine < 2)
				lnQ.push_back({expCnt, m8 ? rnd : {rnd[3:0], 4'h0}});
			else if (armed)
				lnQ.push_back(16'h0000);
		end
	end

	// watcher: oldest note against each answer
	always @(posedge sys_clk) begin
		if (rdDly) begin
			ent = rdQ.pop_front();
			check(regRdData & ent[15:8], ent[7:0], "read data");
		end
		rdDly <= regRead;
		if (lineDone && lnQ.size() != 0) begin
			ent = lnQ.pop_front();
			lines++;
			check(shiftCount, ent[15:8], "shift count");
			if (ent[15:8] != 8'h00)
				check(lastData, ent[7:0], "panel data");
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		foreach (rstAddr[k]) rd(rstAddr[k], 8'h00, 8'hFF);
		foreach (wbAddr[k]) begin
			wr(wbAddr[k], 8'hFF);
			rd(wbAddr[k], wbExp[k], 8'hFF);
		end
		// 16 Ts display, 32 Ts blank, 2 display and 4 blank lines
		wr(8'h32, 8'h01);
		wr(8'h34, 8'h03);
		wr(8'h38, 8'h01);
		wr(8'h39, 8'h00);
		rd(8'h38, 8'h01, 8'hFF);
		// every mode and depth; the long ac delay on odd steps
		for (int i = 0; i < 4; i++) begin
			m8 = i[1];
			expCnt = m8 ? 8'h04 : 8'h0E;
			wr(8'h31, {7'h00, i[0]});
			wr(8'h40, {5'h00, i[0], i[1], 1'b1});
			base = lines;
			go <= 1'b1;
			repeat (1500) @(posedge sys_clk);
			check(8'(lines - base >= 6), 8'h01, "lines seen");
			// status shows the line pulse while it stands
			do @(posedge sys_clk); while (!(linePulse && !lineWas));
			rd(8'h41, 8'h02, 8'h02);
			go <= 1'b0;
			wr(8'h40, 8'h00);
		end
		// reset in mid-run clears the pulse, shift, ac and take outputs and the mode register
		wr(8'h40, 8'h01);
		repeat (300) @(posedge sys_clk);
		sys_rst <= 1'b1;
		@(posedge sys_clk);
		#1;
		check({2'b00, framePulse, linePulse, primaryShiftClock,
			secondaryShiftClock, acDriveOutput, pixelTake}, 8'h00, "outputs");
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd(8'h40, 8'h00, 8'hFF);
		repeat (4) @(posedge sys_clk);
		end_of_test();
	end

	// watchdog well beyond the expected run length
	initial begin
		#100000;
		errors++;
		end_of_test();
	end
endmodule // tb_top

bind color_stn_panel_timing color_stn_panel_timing_assertions #(
	.HALF_DIV(HALF_DIV)) u_color_stn_panel_timing_assertions (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
	.regRdData(regRdData), .pixelIn(pixelIn), .pixelTake(pixelTake),
	.framePulse(framePulse), .linePulse(linePulse),
	.primaryShiftClock(primaryShiftClock),
	.secondaryShiftClock(secondaryShiftClock),
	.panelPixelData(panelPixelData), .acDriveOutput(acDriveOutput));
